// ===== rtl/rsc_pkg.sv
// package: register map, cause bits and timing constants of the reset controller
package rsc_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] RSC_OFF_CAUSE   = 8'h00; // reset_cause_flags
   localparam logic [7:0] RSC_OFF_BLKCTL  = 8'h04; // block_reset_control
   localparam logic [7:0] RSC_OFF_CORECTL = 8'h08; // core_interrupt_reset_ctrl
   localparam logic [7:0] RSC_OFF_PROG    = 8'h0c; // programming_control
   // ==========================================================
   // field positions
   localparam int RSC_CAUSE_POR   = 0;
   localparam int RSC_CAUSE_PIN   = 1;
   localparam int RSC_CAUSE_WDT   = 2;
   localparam int RSC_CAUSE_LVR   = 3;
   localparam int RSC_CAUSE_BOD   = 4;
   localparam int RSC_CAUSE_MCU   = 5;
   localparam int RSC_CAUSE_CORE  = 7;
   localparam int RSC_BLK_CHIP    = 0;
   localparam int RSC_BLK_CORE    = 1;
   localparam int RSC_CORE_REBOOT = 2;
   localparam int RSC_PROG_BOOT   = 1;
   localparam int RSC_NUM_SRC     = 8;
   // ==========================================================
   // values after reset
   localparam logic [7:0] RSC_CAUSE_RST = 8'h01;
   localparam logic       RSC_BOOT_RST  = 1'b0;
   // ==========================================================
   // reset pulse length
   localparam int         RSC_CLK_MHZ      = 50;
   localparam int         RSC_PULSE_NS     = 320;
   localparam int         RSC_PULSE_CYC    = (RSC_PULSE_NS * RSC_CLK_MHZ + 999) / 1000;
   localparam logic [4:0] RSC_PULSE_CYC_W  = 5'(RSC_PULSE_CYC);
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0]
   {
      RSC_ST_RUN  = 3'b001,
      RSC_ST_HOLD = 3'b010,
      RSC_ST_REL  = 3'b100
   } rsc_state_t;
   // reset scope
   typedef enum logic [1:0]
   {
      RSC_SC_CORE = 2'h0,
      RSC_SC_SYS  = 2'h1,
      RSC_SC_CHIP = 2'h2
   } rsc_scope_t;
endpackage : rsc_pkg

// ===== rtl/rsc_src_if.sv
// interface: synchronised reset source requests between sync and sequencer
`timescale 1ns/100ps
interface rsc_src_if;
   logic [7:0] req;
   modport src (output req);
   modport dst (input  req);
endinterface : rsc_src_if

// ===== rtl/rsc_src_sync.sv
// module: two-flop synchronisers for hardware reset sources
`timescale 1ns/100ps
module rsc_src_sync
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // raw sources
   input  wire logic [7:0] raw_i,
   // synchronised requests
   rsc_src_if.src          sync_o
);
   import rsc_pkg::*;
   logic [7:0] meta_r;
   logic [7:0] sync_r;
   // ==========================================================
   // per-bit synchroniser chain
   genvar g;
   generate
      for (g = 0; g < RSC_NUM_SRC; g++)
      begin : g_sync
         always_ff @(posedge clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
            begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end
            else
            begin
               meta_r[g] <= raw_i[g];
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate
   assign sync_o.req = sync_r;
endmodule : rsc_src_sync

// ===== rtl/rsc_top.sv
// module: system reset source controller top
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - cause flags: bit0 power/chip, 1 pin, 2 watchdog, 3 low volt, 4 brownout, 5 mcu, 7 core
// - power-on, pin low, watchdogs, low voltage, brownout are hardware sources
// - writing 1 to control bit 0 resets the whole chip
// - writing 1 to reboot bit 2 reboots, keeping boot select
// - writing 1 to control bit 1 resets only the core
// - power-on or chip reset clears peripherals, crystal and boot select bit
// - reboot resets peripherals but keeps crystal and boot select
// - every source except core-only resets core and peripherals
// - seven distinct reset causes are flagged; both watchdogs share bit 2
module rsc_top
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // hardware reset sources
   input  wire logic        ext_reset_pin_n_i,
   input  wire logic        wdt_timeout_i,
   input  wire logic        wwdt_timeout_i,
   input  wire logic        low_voltage_reset_i,
   input  wire logic        brownout_reset_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // reset outputs, active low
   output logic             core_reset_n_o,
   output logic             periph_reset_n_o,
   output logic             xtal_reset_n_o,
   // boot select bit
   output logic             boot_select_o
);
   import rsc_pkg::*;

   // ==========================================================
   // source synchronisation
   rsc_src_if  src_bus ();
   logic [7:0] raw_src;
   logic [7:0] hw_req;
   logic       sw_chip;
   logic       sw_mcu;
   logic       sw_core;

   // software bits enter the synchroniser as plain zero lanes
   assign raw_src = {3'h0, brownout_reset_i, low_voltage_reset_i,
                     wdt_timeout_i | wwdt_timeout_i, ~ext_reset_pin_n_i, 1'b0};

   rsc_src_sync u_sync
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .raw_i     (raw_src),
      .sync_o    (src_bus.src)
   );
   assign hw_req = src_bus.req;

   // ==========================================================
   // software request decode
   logic wr_blk;
   logic wr_core;
   logic wr_prog;
   assign wr_blk  = reg_wr_i && (reg_addr_i == RSC_OFF_BLKCTL);
   assign wr_core = reg_wr_i && (reg_addr_i == RSC_OFF_CORECTL);
   assign wr_prog = reg_wr_i && (reg_addr_i == RSC_OFF_PROG);
   assign sw_chip = wr_blk  && reg_wdata_i[RSC_BLK_CHIP];
   assign sw_core = wr_blk  && reg_wdata_i[RSC_BLK_CORE] && !sw_chip;
   assign sw_mcu  = wr_core && reg_wdata_i[RSC_CORE_REBOOT];

   // ==========================================================
   // request classification
   logic       any_hw;
   logic       req_any;
   rsc_scope_t req_scope;
   logic [7:0] req_cause;
   assign any_hw  = |hw_req[RSC_CAUSE_BOD:RSC_CAUSE_PIN];
   assign req_any = any_hw | sw_chip | sw_mcu | sw_core;

   // widest scope wins when several sources coincide
   always_comb
   begin
      req_cause = 8'h00;
      req_cause[RSC_CAUSE_PIN] = hw_req[RSC_CAUSE_PIN];
      req_cause[RSC_CAUSE_WDT] = hw_req[RSC_CAUSE_WDT];
      req_cause[RSC_CAUSE_LVR] = hw_req[RSC_CAUSE_LVR];
      req_cause[RSC_CAUSE_BOD] = hw_req[RSC_CAUSE_BOD];
      req_cause[RSC_CAUSE_POR] = sw_chip;
      req_cause[RSC_CAUSE_MCU] = sw_mcu;
      req_cause[RSC_CAUSE_CORE] = sw_core;
      if (sw_chip)
         req_scope = RSC_SC_CHIP;
      else if (any_hw || sw_mcu)
         req_scope = RSC_SC_SYS;
      else
         req_scope = RSC_SC_CORE;
   end

   // ==========================================================
   // sequencer
   rsc_state_t state_r;
   rsc_state_t state_nxt;
   rsc_scope_t scope_r;
   logic [4:0] cnt_r;
   logic       hold_done;
   assign hold_done = (cnt_r == 5'h00);

   // state register
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_r <= RSC_ST_HOLD;
      else
         state_r <= state_nxt;
   end

   // next state: hold while a source stays active or count runs
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         RSC_ST_RUN:
            if (req_any)
               state_nxt = RSC_ST_HOLD;
         RSC_ST_HOLD:
            if (hold_done && !req_any)
               state_nxt = RSC_ST_REL;
         RSC_ST_REL:
            if (req_any)
               state_nxt = RSC_ST_HOLD;                      // a late request is not lost
            else
               state_nxt = RSC_ST_RUN;
      endcase
   end

   // hold counter, reloaded by every new or lasting request
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cnt_r <= RSC_PULSE_CYC_W;
      else if (req_any)
         cnt_r <= RSC_PULSE_CYC_W;
      else if (state_r == RSC_ST_HOLD && !hold_done)
         cnt_r <= cnt_r - 5'h01;
   end

   // scope register, widened during a hold, never narrowed
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         scope_r <= RSC_SC_CHIP;
      else if (req_any && (state_r != RSC_ST_HOLD || req_scope > scope_r))
         scope_r <= req_scope;
   end

   // ==========================================================
   // reset outputs
   logic in_hold;
   assign in_hold = (state_r == RSC_ST_HOLD);

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         core_reset_n_o   <= 1'b0;
         periph_reset_n_o <= 1'b0;
         xtal_reset_n_o   <= 1'b0;
      end
      else
      begin
         core_reset_n_o   <= !in_hold;
         periph_reset_n_o <= !(in_hold && scope_r != RSC_SC_CORE);
         xtal_reset_n_o   <= !(in_hold && scope_r == RSC_SC_CHIP);
      end
   end

   // boot select: cleared by chip-wide reset, kept by reboot
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         boot_select_o <= RSC_BOOT_RST;
      else if (in_hold && scope_r == RSC_SC_CHIP)
         boot_select_o <= RSC_BOOT_RST;
      else if (wr_prog && !in_hold)
         boot_select_o <= reg_wdata_i[RSC_PROG_BOOT];
   end

   // ==========================================================
   // cause flags: set wins over write-one-to-clear
   logic [7:0] cause_r;
   logic [7:0] cause_nxt;
   always_comb
   begin
      cause_nxt = cause_r;
      if (reg_wr_i && reg_addr_i == RSC_OFF_CAUSE)
         cause_nxt = cause_r & ~reg_wdata_i[7:0];
      cause_nxt = cause_nxt | req_cause;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cause_r <= RSC_CAUSE_RST;
      else
         cause_r <= cause_nxt;
   end

   // ==========================================================
   // read port, data one cycle after strobe
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr_i)
         RSC_OFF_CAUSE:   rd_mux = {24'h00_0000, cause_r};
         RSC_OFF_BLKCTL:  rd_mux = 32'h0000_0000;  // self-clearing triggers
         RSC_OFF_CORECTL: rd_mux = 32'h0000_0000;
         RSC_OFF_PROG:    rd_mux = {30'h0, boot_select_o, 1'b0};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_rd_i)
         reg_rdata_o <= rd_mux;
      else
         reg_rdata_o <= 32'h0000_0000;
   end

   // ==========================================================
   // checks
   // cycles since the last request, saturating, for the release check
   logic [4:0] quiet_cnt_r;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         quiet_cnt_r <= 5'h00;
      else if (req_any)
         quiet_cnt_r <= 5'h00;
      else if (quiet_cnt_r != 5'h1f)
         quiet_cnt_r <= quiet_cnt_r + 5'h01;
   end

   a_core_only_scope: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == RSC_ST_RUN && sw_core && !any_hw) |=> ##1 (!core_reset_n_o && periph_reset_n_o))
      else $error("core reset touched peripherals");
   a_chip_clears_xtal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == RSC_ST_RUN && sw_chip) |=> ##1 (!xtal_reset_n_o && !periph_reset_n_o))
      else $error("chip reset missed crystal");
   a_reboot_keeps_boot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == RSC_ST_RUN && sw_mcu && !sw_chip && !any_hw) |=> ##1
      (!periph_reset_n_o && xtal_reset_n_o && $stable(boot_select_o)))
      else $error("reboot disturbed boot select");
   a_mcu_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sw_mcu |=> cause_r[RSC_CAUSE_MCU])
      else $error("mcu cause flag not set");
   a_hw_holds_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hw_req[RSC_CAUSE_BOD] |=> ##1 (!core_reset_n_o && !periph_reset_n_o))
      else $error("brownout did not reset");
   a_pulse_min_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $fell(core_reset_n_o) |-> !core_reset_n_o [*8])
      else $error("reset pulse too short");
   a_pin_flag_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hw_req[RSC_CAUSE_PIN] |=> cause_r[RSC_CAUSE_PIN])
      else $error("pin cause flag not set");
   a_chip_boot_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (in_hold && scope_r == RSC_SC_CHIP) |=> !boot_select_o)
      else $error("boot select survived chip reset");
   a_release_bounded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (quiet_cnt_r >= RSC_PULSE_CYC_W + 5'h02) |-> core_reset_n_o)
      else $error("core reset never released");
endmodule : rsc_top

// ===== sim/rsc_src_model.sv
// partner model: on-chip hardware reset sources facing the controller
`timescale 1ns/100ps
module rsc_src_model
(
   // source selection from the bench
   input  wire logic [2:0] sel_i,
   input  wire logic       on_i,
   // source lines toward the controller
   output logic            pin_n_o,
   output logic            wdt_o,
   output logic            wwdt_o,
   output logic            lvr_o,
   output logic            bod_o
);
   // ==========================================================
   // source lines
   // one source at a time; the pin idles high through its pull-up
   assign pin_n_o = ~(on_i && sel_i == 3'h0);
   assign wdt_o   = on_i && sel_i == 3'h1;
   assign wwdt_o  = on_i && sel_i == 3'h2;
   assign lvr_o   = on_i && sel_i == 3'h3;
   assign bod_o   = on_i && sel_i == 3'h4;
endmodule : rsc_src_model

// ===== sim/rsc_top_tb_top.sv
// testbench: reset controller against a behavioural model of causes and scopes
`timescale 1ns/100ps
module rsc_top_tb_top;
   import rsc_pkg::*;
   // ==========================================================
   // signals and model state
   logic        clk_i;
   logic        reset_n_i;
   logic [7:0]  reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic        core_reset_n_o;
   logic        periph_reset_n_o;
   logic        xtal_reset_n_o;
   logic        boot_select_o;
   logic        pin_n, wdt, wwdt, low_voltage_reset, brownout_reset;
   logic [2:0]  src_sel;
   logic        src_on;
   logic [31:0] rnd;
   int          n_mismatch;
   int          tests_run;
   int          exp_cause;
   int          exp_boot;
   int          src_bit [5] = '{RSC_CAUSE_PIN, RSC_CAUSE_WDT, RSC_CAUSE_WDT,
                                RSC_CAUSE_LVR, RSC_CAUSE_BOD};
   // ==========================================================
   // clock, design and partner
   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;
   rsc_top u_rsc_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .ext_reset_pin_n_i(pin_n),
      .wdt_timeout_i(wdt), .wwdt_timeout_i(wwdt), .low_voltage_reset_i(low_voltage_reset),
      .brownout_reset_i(brownout_reset), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .core_reset_n_o(core_reset_n_o), .periph_reset_n_o(periph_reset_n_o),
      .xtal_reset_n_o(xtal_reset_n_o), .boot_select_o(boot_select_o));
   rsc_src_model u_rsc_src_model (.sel_i(src_sel), .on_i(src_on), .pin_n_o(pin_n),
      .wdt_o(wdt), .wwdt_o(wwdt), .lvr_o(low_voltage_reset), .bod_o(brownout_reset));
   // ==========================================================
   // helpers
   // xorshift step for random stimulus
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   endfunction : xs
   // compares and counts
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr
   // one-cycle read strobe, data looked at in the cycle after it
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      check("reg_rdata_o", reg_rdata_o, e);
   endtask : rd
   // waits for core reset, checks scope, hold length and joint release
   task automatic hold_check(input logic ep, input logic ex);
      int n;
      for (n = 0; n < 8 && core_reset_n_o !== 1'b0; n++)
      begin
         @(posedge clk_i);
         #1;
      end
      #1;
      check("core_reset_n_o", core_reset_n_o, 32'h0);
      check("periph_reset_n_o", periph_reset_n_o, ep);
      check("xtal_reset_n_o", xtal_reset_n_o, ex);
      for (n = 0; n < 80 && core_reset_n_o !== 1'b1; n++)
      begin
         @(posedge clk_i);
         #1;
      end
      check("hold_cycles", 32'(n >= RSC_PULSE_CYC), 32'h1);
      @(posedge clk_i);
      #1;
      check("outs_high", {core_reset_n_o, periph_reset_n_o, xtal_reset_n_o}, 32'h7);
   endtask : hold_check
   // reads cause and boot select against the model, then clears the flags
   task automatic events_check();
      rd(RSC_OFF_CAUSE, exp_cause);
      check("boot_select_o", boot_select_o, exp_boot);
      rd(RSC_OFF_PROG, exp_boot << RSC_PROG_BOOT);
      rnd = xs(rnd);
      wr(RSC_OFF_CAUSE, rnd | 32'hff);
      exp_cause = 0;
      rd(RSC_OFF_CAUSE, 32'h0);
   endtask : events_check
   // software request with boot select set beforehand
   task automatic sw_event(input logic [7:0] a, input logic [31:0] d, input int cbit,
                           input logic ep, input logic ex);
      wr(RSC_OFF_PROG, 32'h2);
      exp_boot = 1;
      wr(a, d);
      if (ex === 1'b0) exp_boot = 0;
      hold_check(ep, ex);
      exp_cause = exp_cause | (1 << cbit);
      events_check();
   endtask : sw_event
   // hardware source pulse of random length from the partner
   task automatic hw_event(input int k, input int cbit);
      int len;
      wr(RSC_OFF_PROG, 32'h2);
      exp_boot = 1;
      rnd = xs(rnd);
      len = 2 + int'(rnd[2:0]);
      @(posedge clk_i);
      src_sel <= 3'(k);
      src_on  <= 1'b1;
      repeat (len) @(posedge clk_i);
      src_on  <= 1'b0;
      hold_check(1'b0, 1'b1);
      exp_cause = exp_cause | (1 << cbit);
      events_check();
   endtask : hw_event
   // verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // main sequence
   initial
   begin
      n_mismatch  = 0;
      tests_run   = 0;
      exp_cause   = RSC_CAUSE_RST;
      exp_boot    = 0;
      rnd         = 32'h0000cfa0;
      reset_n_i   = 1'b0;
      reg_addr_i  = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i    = 1'b0;
      reg_rd_i    = 1'b0;
      src_sel     = 3'h0;
      src_on      = 1'b0;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      hold_check(1'b0, 1'b0);
      events_check();
      rnd = xs(rnd);
      wr(8'h10, rnd);
      rd(8'h10, 32'h0);
      sw_event(RSC_OFF_BLKCTL, 32'h1 << RSC_BLK_CORE, RSC_CAUSE_CORE, 1'b1, 1'b1);
      sw_event(RSC_OFF_CORECTL, 32'h1 << RSC_CORE_REBOOT, RSC_CAUSE_MCU, 1'b0, 1'b1);
      sw_event(RSC_OFF_BLKCTL, 32'h1 << RSC_BLK_CHIP, RSC_CAUSE_POR, 1'b0, 1'b0);
      for (int k = 0; k < 5; k++) hw_event(k, src_bit[k]);
      end_of_test();
   end
   // watchdog against a hung run
   initial
   begin
      #(20 * 5000);
      n_mismatch++;
      end_of_test();
   end
endmodule : rsc_top_tb_top
